// >>> src/adc_ctrl_pkg.sv
// constants for the converter control block: register map, fields, timing
// assumes a byte-wide peripheral bus with write/bit-write strobes on one clock
package adc_ctrl_pkg;
    localparam logic [15:0] MODE_ADDR      = 16'hff80;
    localparam logic [15:0] CHAN_ADDR      = 16'hff81;
    localparam logic [7:0]  MODE_RESET     = 8'h00;
    localparam logic [7:0]  CHAN_RESET     = 8'h00;
    localparam int          RUN_BIT        = 7;
    localparam int          TSEL_LSB       = 3;
    localparam int          CMP_BIT        = 0;
    localparam logic [7:0]  MODE_MASK      = 8'hb9;
    localparam logic [7:0]  CHAN_MASK      = 8'h03;
    localparam int          RESULT_BITS    = 10;
    localparam int          COUNT_BITS     = 8;
    // per timing select: upper byte is sampling clocks, lower byte is total clocks
    localparam logic [15:0] TIMING_SEL0    = 16'h0c24;
    localparam logic [15:0] TIMING_SEL1    = 16'h1830;
    localparam logic [15:0] TIMING_SEL2    = 16'h3048;
    localparam logic [15:0] TIMING_SEL3    = 16'h5870;
    localparam logic [15:0] TIMING_SEL4    = 16'h1848;
    localparam logic [15:0] TIMING_SEL5    = 16'h3060;
    localparam logic [15:0] TIMING_SEL6    = 16'h6090;
    localparam logic [15:0] TIMING_SEL7    = 16'hb0e0;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_e;
endpackage : adc_ctrl_pkg

// >>> src/adc_ctrl.sv
// converter control: mode/channel registers, timing sequencer, sar stepping
// assumes comparator output is already synchronised to the peripheral clock
// assumes software keeps the timing select steady while converting; sar steps each take a tenth of the time after sampling, rounded down
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_write,
    input  wire logic        reg_bit_write,
    input  wire logic [2:0]  reg_bit_index,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        comparator_out,
    output logic             comparator_power_on_out,
    output logic             sample_hold_track,
    output logic      [1:0]  analog_input_sel,
    output logic      [9:0]  dac_code,
    output logic      [9:0]  result_10bit,
    output logic      [7:0]  result_high_byte,
    output logic             conversion_done_irq
);
    import adc_ctrl_pkg::*;

    // sampling and total counts per timing select
    function automatic logic [15:0] timing_counts(input logic [2:0] sel);
        case (sel)
            3'b000:  timing_counts = TIMING_SEL0;
            3'b100:  timing_counts = TIMING_SEL4;
            3'b110:  timing_counts = TIMING_SEL6;
            3'b101:  timing_counts = TIMING_SEL5;
            3'b010:  timing_counts = TIMING_SEL2;
            3'b001:  timing_counts = TIMING_SEL1;
            3'b111:  timing_counts = TIMING_SEL7;
            default: timing_counts = TIMING_SEL3;
        endcase
    endfunction : timing_counts

    logic [7:0]            mode_reg;
    logic [7:0]            mode_next;
    logic [7:0]            chan_reg;
    logic [7:0]            chan_next;
    conv_state_e           state_reg;
    conv_state_e           state_next;
    logic [COUNT_BITS-1:0] count_reg;
    logic [9:0]            sar_reg;
    logic [9:0]            trial_reg;
    logic [9:0]            result_reg;
    logic                  done_reg;

    wire        mode_hit   = (reg_addr == MODE_ADDR);
    wire        chan_hit   = (reg_addr == CHAN_ADDR);
    wire        any_write  = (reg_write | reg_bit_write) & (mode_hit | chan_hit);
    wire [7:0]  bit_sel    = 8'h01 << reg_bit_index;
    wire        run        = mode_reg[RUN_BIT];
    wire        run_new    = mode_next[RUN_BIT];
    wire [2:0]  tsel       = mode_reg[TSEL_LSB +: 3];
    wire [15:0] counts     = timing_counts(tsel);
    wire [7:0]  samp_count = counts[15:8];
    wire [7:0]  total_count = counts[7:0];
    // reload follows the byte being written, so a combined write and start samples for the new time
    wire [15:0] counts_new = timing_counts(mode_next[TSEL_LSB +: 3]);
    wire [7:0]  samp_next  = counts_new[15:8];
    // each step of sar takes a tenth of the time after sampling, rounded down to whole clocks
    wire [7:0]  step_len   = 8'((total_count - samp_count) / 8'd10);
    wire        last_step  = trial_reg[0];

    // byte write replaces, bit write merges one bit; reserved bits stay zero
    always_comb
    begin
        mode_next = mode_reg;
        chan_next = chan_reg;
        if (mode_hit && reg_write)
            mode_next = reg_wdata & MODE_MASK;
        else if (mode_hit && reg_bit_write)
            mode_next = ((mode_reg & ~bit_sel) | (bit_sel & {8{reg_wdata[0]}})) & MODE_MASK;
        if (chan_hit && reg_write)
            chan_next = reg_wdata & CHAN_MASK;
        else if (chan_hit && reg_bit_write)
            chan_next = ((chan_reg & ~bit_sel) | (bit_sel & {8{reg_wdata[0]}})) & CHAN_MASK;
    end

    // a write restarts from sampling if the start bit is set, else returns to idle; otherwise sequencer steps on
    always_comb
    begin
        state_next = state_reg;
        if (any_write)
            state_next = run_new ? ST_SAMPLE : ST_IDLE;
        else
            case (state_reg)
                ST_IDLE:    state_next = run ? ST_SAMPLE : ST_IDLE;
                ST_SAMPLE:  if (count_reg == 8'd1) state_next = ST_CONVERT;
                ST_CONVERT: if (count_reg == 8'd1 && last_step)
                                state_next = run ? ST_SAMPLE : ST_IDLE;
                default:    state_next = ST_IDLE;
            endcase
    end

    // software-visible registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            mode_reg <= MODE_RESET;
            chan_reg <= CHAN_RESET;
        end
        else
        begin
            mode_reg <= mode_next;
            chan_reg <= chan_next;
        end
    end

    // counter reloads on entry to each phase and each sar step
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg <= ST_IDLE;
            count_reg <= '0;
            sar_reg   <= '0;
            trial_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next == ST_SAMPLE && state_reg != ST_SAMPLE || any_write)
                count_reg <= samp_next;
            else if (state_next == ST_CONVERT && count_reg == 8'd1)
                count_reg <= step_len;
            else if (count_reg != 8'd0)
                count_reg <= count_reg - 8'd1;
            if (state_reg == ST_SAMPLE && state_next == ST_CONVERT)
            begin
                trial_reg <= 10'h200;
                sar_reg   <= 10'h000;
            end
            else if (state_reg == ST_CONVERT && count_reg == 8'd1)
            begin
                if (comparator_out)
                    sar_reg <= sar_reg | trial_reg;
                trial_reg <= trial_reg >> 1;
            end
        end
    end

    // result latched after the tenth decision; done pulses one cycle
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            result_reg <= '0;
            done_reg   <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (state_reg == ST_CONVERT && count_reg == 8'd1 && last_step && !any_write)
            begin
                result_reg <= comparator_out ? (sar_reg | trial_reg) : sar_reg;
                done_reg   <= 1'b1;
            end
        end
    end

    // read mux; unmapped addresses read zero, upper channel bits zero
    assign reg_rdata = mode_hit ? mode_reg : (chan_hit ? chan_reg : 8'h00);
    assign comparator_power_on_out = mode_reg[CMP_BIT] | run;
    assign sample_hold_track   = (state_reg == ST_SAMPLE);
    assign analog_input_sel    = chan_reg[1:0];
    assign dac_code            = sar_reg | trial_reg;
    assign result_10bit        = result_reg;
    assign result_high_byte    = result_reg[9:2];
    assign conversion_done_irq = done_reg;

    // register access and reset checks
    a_reset_mode: assert property (@(posedge clock)
        srst |=> mode_reg == 8'h00 && state_reg == ST_IDLE)
        else $error("mode not cleared by reset");
    a_reset_chan: assert property (@(posedge clock)
        srst |=> chan_reg == 8'h00 && !done_reg)
        else $error("channel not cleared by reset");
    a_mode_reserved: assert property (@(posedge clock) disable iff (srst)
        (reg_rdata & {8{mode_hit}} & 8'h46) == 8'h00)
        else $error("reserved mode bit set");
    a_bit_write_run: assert property (@(posedge clock) disable iff (srst)
        mode_hit && reg_bit_write && !reg_write && reg_bit_index == 3'(RUN_BIT) |=> run == $past(reg_wdata[0]))
        else $error("start bit write lost");
    a_chan_bit: assert property (@(posedge clock) disable iff (srst)
        chan_hit && reg_bit_write && !reg_write && reg_bit_index == 3'h0 |=> chan_reg[0] == $past(reg_wdata[0]))
        else $error("channel bit write lost");
    a_chan_upper: assert property (@(posedge clock) disable iff (srst)
        chan_reg[7:2] == 6'h00)
        else $error("channel upper bits set");
    a_power_gate: assert property (@(posedge clock) disable iff (srst)
        (mode_reg[7] | mode_reg[0]) == comparator_power_on_out)
        else $error("comparator power wrong");

    // sequencer timing checks
    a_run_starts: assert property (@(posedge clock) disable iff (srst)
        run && state_reg == ST_IDLE && !any_write |=> state_reg == ST_SAMPLE)
        else $error("start did not begin sampling");
    a_stop_holds: assert property (@(posedge clock) disable iff (srst)
        !run && state_reg == ST_IDLE && !any_write |=> state_reg == ST_IDLE && !done_reg)
        else $error("stopped converter moved");
    a_write_abort: assert property (@(posedge clock) disable iff (srst)
        any_write && run_new |=> state_reg == ST_SAMPLE && count_reg == samp_count)
        else $error("write did not restart");
    a_stop_idle: assert property (@(posedge clock) disable iff (srst)
        any_write && !run_new |=> state_reg == ST_IDLE)
        else $error("write with stop did not idle");
    a_sample_load: assert property (@(posedge clock) disable iff (srst)
        $rose(sample_hold_track) |-> count_reg == samp_count)
        else $error("sampling count not loaded");
    a_sample_end: assert property (@(posedge clock) disable iff (srst)
        state_reg == ST_SAMPLE && count_reg == 8'd1 && !any_write
        |=> state_reg == ST_CONVERT && count_reg == step_len)
        else $error("sampling did not end on count");
    a_first_trial: assert property (@(posedge clock) disable iff (srst)
        $fell(sample_hold_track) && state_reg == ST_CONVERT |-> dac_code == 10'h200)
        else $error("first trial not at mid scale");

    // result hand-off checks
    a_repeat_run: assert property (@(posedge clock) disable iff (srst)
        state_reg == ST_CONVERT && count_reg == 8'd1 && last_step && run && !any_write
        |=> state_reg == ST_SAMPLE && done_reg && count_reg == samp_count)
        else $error("conversion did not repeat");
    a_done_result: assert property (@(posedge clock) disable iff (srst)
        done_reg |-> state_reg != ST_CONVERT && result_high_byte == result_10bit[9:2])
        else $error("done without result");
    a_done_pulse: assert property (@(posedge clock) disable iff (srst)
        done_reg |=> !done_reg)
        else $error("done longer than one cycle");
endmodule : adc_ctrl
`default_nettype wire

// >>> verif/adc_ctrl_bench.sv
// bench for the converter control block: register access, timing table, repeat, abort
// assumes a comparator that follows the dac code against a fixed target
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_bench;
    import adc_ctrl_pkg::*;
    logic        clock = 0, srst = 1, reg_write = 0, reg_bit_write = 0, comparator_out = 0;
    logic [15:0] reg_addr = 16'h0000;
    logic [2:0]  reg_bit_index = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata, result_high_byte;
    logic [9:0]  dac_code, result_10bit, target = 10'h0000;
    logic [1:0]  analog_input_sel;
    logic        power_on, track, done;
    int          failures = 0, compares = 0, n;
    int          samp_t[8] = '{12, 24, 48, 88, 24, 48, 96, 176};
    int          tot_t[8]  = '{36, 48, 72, 112, 72, 96, 144, 224};

    always #2 clock = ~clock;
    // ideal comparator: input at or above the tap gives one
    always @(negedge clock) comparator_out <= (target >= dac_code);

    adc_ctrl u_adc_ctrl (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_bit_write(reg_bit_write), .reg_bit_index(reg_bit_index), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .comparator_out(comparator_out), .comparator_power_on_out(power_on),
        .sample_hold_track(track), .analog_input_sel(analog_input_sel), .dac_code(dac_code),
        .result_10bit(result_10bit), .result_high_byte(result_high_byte), .conversion_done_irq(done));

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // one strobe cycle; a bit write carries the value in data bit 0
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bitw, input logic [2:0] idx);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_bit_index = idx;
        reg_write = !bitw;
        reg_bit_write = bitw;
        @(negedge clock);
        reg_write = 0;
        reg_bit_write = 0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        #1 chk({2'b00, reg_rdata}, {2'b00, exp}, "read");
    endtask : rd

    // set timing while stopped, then start by bit write; measure sampling and repeat period
    task automatic conv(input int t);
        int hi;
        int per;
        int base;
        hi = 0;
        per = 1;
        base = samp_t[t] + 10 * ((tot_t[t] - samp_t[t]) / 10);
        target = 10'(t * 131 + 5);
        wr(MODE_ADDR, 8'(t << TSEL_LSB), 0, 0);
        repeat (2) @(negedge clock);
        wr(MODE_ADDR, 8'h01, 1, 3'(RUN_BIT));
        while (!track) @(negedge clock);
        while (track)
        begin
            hi++;
            @(negedge clock);
        end
        chk(10'(hi), 10'(samp_t[t]), "sample length");
        while (!done) @(negedge clock);
        chk(result_10bit, target, "result");
        chk({2'b00, result_high_byte}, {2'b00, target[9:2]}, "high byte");
        @(negedge clock);
        while (!done && per < 400)
        begin
            per++;
            @(negedge clock);
        end
        chk(10'(per >= base && per <= base + 2), 10'h0001, "repeat period");
        wr(MODE_ADDR, 8'(t << TSEL_LSB), 0, 0);
    endtask : conv

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    // about 2400 cycles are expected; allow over eight times that
    initial
    begin
        #80000;
        failures++;
        finish_test();
    end

    initial
    begin
        repeat (16) @(posedge clock);
        @(negedge clock);
        srst = 0;
        rd(MODE_ADDR, MODE_RESET);
        rd(CHAN_ADDR, CHAN_RESET);
        chk({9'h000, power_on}, 10'h0000, "power after reset");
        wr(MODE_ADDR, MODE_MASK & 8'h7f, 0, 0);
        rd(MODE_ADDR, MODE_MASK & 8'h7f);
        wr(MODE_ADDR, 8'h00, 0, 0);
        wr(CHAN_ADDR, 8'hff, 0, 0);
        rd(CHAN_ADDR, CHAN_MASK);
        chk({8'h00, analog_input_sel}, 10'h0003, "channel");
        wr(CHAN_ADDR, 8'h00, 1, 3'h0);
        rd(CHAN_ADDR, 8'h02);
        rd(16'hff82, 8'h00);
        $display("test registers done");
        for (int t = 0; t < 8; t++) conv(t);
        $display("test timing done");
        // abort mid conversion by a channel write; a fresh full 216-cycle select-7 conversion must follow
        wr(MODE_ADDR, 8'h01, 1, 3'(RUN_BIT));
        while (track) @(negedge clock);
        repeat (10) @(negedge clock);
        wr(CHAN_ADDR, 8'h01, 0, 0);
        n = 1;
        while (!done && n < 400)
        begin
            n++;
            @(negedge clock);
        end
        chk(10'(n >= 216 && n <= 218), 10'h0001, "restart after write");
        wr(MODE_ADDR, 8'h00, 1, 3'(RUN_BIT));
        n = 0;
        repeat (300) @(negedge clock) n += done;
        chk(10'(n), 10'h0000, "stopped");
        chk({9'h000, power_on}, 10'h0000, "power off");
        wr(MODE_ADDR, 8'h01, 1, 3'(CMP_BIT));
        chk({9'h000, power_on}, 10'h0001, "power on");
        rd(MODE_ADDR, 8'(7 << TSEL_LSB) | 8'h01);
        $display("test abort and power done");
        finish_test();
    end
endmodule : adc_ctrl_bench
`default_nettype wire
